// File: design/lpdbrw_pkg.sv
// Package for the LPDDR burst read/write data path.
// Assumes every user imports it whole; no clocks or state live here.
package lpdbrw_pkg;

  localparam int BANKS  = 4;
  localparam int BANK_W = 2;

  // Command codes as {ras_n, cas_n, we_n} with cs_n low
  localparam logic [2:0] CMD_ACTIVE    = 3'h3;
  localparam logic [2:0] CMD_READ      = 3'h5;
  localparam logic [2:0] CMD_WRITE     = 3'h4;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_BTERM     = 3'h6;

  localparam logic [1:0] CL_TWO   = 2'h2;
  localparam logic [1:0] CL_THREE = 2'h3;

  // Command delay line covers the longest read latency
  localparam int PIPE_DEPTH = 3;

  // Burst length code: 0..3 means 2, 4, 8, 16 elements
  localparam logic [1:0] BL_CODE_RST = 2'h1;
  localparam int         PAIR_W      = 4;

  // Extra cycles after the last write pair before auto precharge
  localparam logic [PAIR_W-1:0] WR_AP_TAIL = 4'h2;

  typedef enum logic [1:0] {
    EV_NONE,
    EV_READ,
    EV_BTERM,
    EV_PRE
  } lpdbrw_ev_e;

  // Element pairs in one burst
  function automatic logic [PAIR_W-1:0] lpdbrw_pairs(
    input logic [1:0] code
  );
    return 4'h1 << code;
  endfunction

  // Column of element e, wrapping inside the burst-aligned block
  function automatic logic [15:0] lpdbrw_col_wrap(
    input logic [15:0] base,
    input logic [15:0] e,
    input logic [1:0]  code
  );
    logic [15:0] mask;
    mask = (16'h2 << code) - 16'h1;
    return (base & ~mask) | ((base + e) & mask);
  endfunction

endpackage

// File: design/lpdbrw_wr_if.sv
// Interface joining the command-clock core to the write-strobe capture.
// Command fields cross as a held word plus a toggle; the memory write
// port is produced in the strobe domain and used only there.
`timescale 1ns/10ps
`default_nettype none
interface lpdbrw_wr_if #(
  parameter int ROW_W = 4,
  parameter int COL_W = 4,
  parameter int DQ_W  = 16
);
  localparam int NB    = DQ_W / 8;
  localparam int IDX_W = 2 + ROW_W + COL_W;

  logic             cmd_tgl;
  logic [1:0]       cmd_bank;
  logic [ROW_W-1:0] cmd_row;
  logic [COL_W-1:0] cmd_col;
  logic [1:0]       cmd_code;
  logic             we;
  logic [IDX_W-1:0] idx;
  logic [DQ_W-1:0]  rise_dq;
  logic [NB-1:0]    rise_keep;

  modport core (
    output cmd_tgl, cmd_bank, cmd_row, cmd_col, cmd_code,
    input  we, idx, rise_dq, rise_keep
  );
  modport cap (
    input  cmd_tgl, cmd_bank, cmd_row, cmd_col, cmd_code,
    output we, idx, rise_dq, rise_keep
  );
endinterface
`default_nettype wire

// File: design/lpdbrw_wcap.sv
// Write strobe side: catches write tokens and rising-edge data elements.
// Runs on the controller's write strobe; the core writes the pair on the
// falling edge from what this module holds.
`timescale 1ns/10ps
`default_nettype none
module lpdbrw_wcap
  import lpdbrw_pkg::*;
#(
  parameter int ROW_W = 4,
  parameter int COL_W = 4,
  parameter int DQ_W  = 16
) (
  input  wire logic              wstrobe_clk,
  input  wire logic              srst,
  input  wire logic [DQ_W-1:0]   dq_in,
  input  wire logic [DQ_W/8-1:0] data_mask,
  lpdbrw_wr_if.cap               wr
);

  logic             rst_s1;
  logic             rst_s2;
  logic             rst_s3;
  logic             lrst;
  logic             tgl_s1;
  logic             tgl_s2;
  logic             tgl_s3;
  logic             tgl_seen;
  logic             new_cmd;
  logic             active;
  logic [PAIR_W-1:0] k;
  logic [PAIR_W-1:0] pairs;
  logic [1:0]       b_bank;
  logic [ROW_W-1:0] b_row;
  logic [COL_W-1:0] b_col;
  logic [1:0]       b_code;
  logic [COL_W-1:0] col_k;

  // Reset and token cross in by three flops; a change counts when
  // the second and third agree
  always_ff @(posedge wstrobe_clk) begin
    rst_s1 <= srst;
    rst_s2 <= rst_s1;
    rst_s3 <= rst_s2;
    tgl_s1 <= wr.cmd_tgl;
    tgl_s2 <= tgl_s1;
    tgl_s3 <= tgl_s2;
  end

  always_ff @(posedge wstrobe_clk) begin
    if (rst_s2 == rst_s3) begin
      lrst <= rst_s3;
    end
  end

  assign new_cmd = (tgl_s2 == tgl_s3) && (tgl_s3 != tgl_seen);
  assign pairs   = lpdbrw_pairs(b_code);
  assign col_k   = COL_W'(lpdbrw_col_wrap(16'(b_col), 16'({k, 1'b0}),
                                          b_code));

  // Token lands during the preamble, before the first rising edge
  always_ff @(posedge wstrobe_clk) begin
    if (lrst) begin
      tgl_seen <= 1'b0;
      active   <= 1'b0;
      k        <= '0;
      wr.we    <= 1'b0;
    end else begin
      if (tgl_s2 == tgl_s3) begin
        tgl_seen <= tgl_s3;
      end
      wr.we <= active;
      if (new_cmd) begin
        active <= 1'b1;
        k      <= '0;
        b_bank <= wr.cmd_bank;
        b_row  <= wr.cmd_row;
        b_col  <= wr.cmd_col;
        b_code <= wr.cmd_code;
      end else if (active) begin
        k <= k + 4'h1;
        if (k + 4'h1 == pairs) begin
          active <= 1'b0;
        end
      end
    end
  end

  // Rising-edge element and its mask, held for the falling edge
  always_ff @(posedge wstrobe_clk) begin
    if (active) begin
      wr.idx       <= {b_bank, b_row, col_k};
      wr.rise_dq   <= dq_in;
      wr.rise_keep <= ~data_mask;
    end
  end

endmodule
`default_nettype wire

// File: design/lpdbrw_core.sv
// Burst read/write data path of a low-power DDR memory, device side.
// Commands are sampled on sys_clk (the command clock); write data comes
// in on the controller's write strobe, wstrobe_clk.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Read drives strobe with data; low preamble before, low on last.
// - First read element on first rising strobe edge, CL 2 or 3.
// - Data pins released once a read burst ends with none pending.
// - Later read extends or cuts earlier read without a gap.
// - Burst terminate ends a read after read latency.
// - Precharge to same bank cuts a non-auto-precharge read.
// - Timely precharge after full read equals auto-precharge read.
// - Burst terminate cuts latest non-auto-precharge read, any bank.
// - Write bursts into open row at column; auto precharge closes.
// - Byte stored only when its mask is low.
// - Write elements taken on successive strobe edges after command.
// - After a write burst, pins stay released and data is ignored.
// - Chained write starts right after the last wanted element.
// - Read accepted after a write burst.
// - Read bursts from open row; auto precharge closes at end (a read cut by another read closes the new read's bank instead).
module lpdbrw_core
  import lpdbrw_pkg::*;
#(
  parameter int ROW_W = 4,
  parameter int COL_W = 4,
  parameter int DQ_W  = 16
) (
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic              wstrobe_clk,
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic              bank_select_msb,
  input  wire logic              bank_select_lsb,
  input  wire logic [ROW_W-1:0]  addr,
  input  wire logic              auto_precharge_bit,
  input  wire logic [1:0]        cas_latency,
  input  wire logic [1:0]        burst_len_code,
  input  wire logic [DQ_W-1:0]   dq_in,
  input  wire logic [DQ_W/8-1:0] data_mask,
  output logic [DQ_W-1:0]        rd_dq_rise,
  output logic [DQ_W-1:0]        rd_dq_fall,
  output logic                   dq_oe,
  output logic                   rd_strobe_rise,
  output logic                   rd_strobe_oe
);

  localparam int NB    = DQ_W / 8;
  localparam int IDX_W = BANK_W + ROW_W + COL_W;
  localparam int MEM_N = 1 << IDX_W;

  // A burst of 16 needs 16 columns; row field carries the column too
  if (DQ_W < 8 || DQ_W % 8 != 0) begin : g_bad_dq
    $error("DQ_W must be a whole number of bytes");
  end
  if (COL_W < 4 || COL_W > 16) begin : g_bad_col
    $error("COL_W must be 4 to 16");
  end
  if (ROW_W < COL_W) begin : g_bad_row
    $error("ROW_W must not be below COL_W");
  end

  // Command decode
  logic              sel;
  logic [2:0]        cmd;
  logic [BANK_W-1:0] cbank;
  logic [COL_W-1:0]  ccol;
  logic              is_act;
  logic              is_rd;
  logic              is_wr;
  logic              is_pre;
  logic              is_bt;
  logic              rd_ok;
  logic              wr_ok;

  // Bank state
  logic [BANKS-1:0]  bank_open;
  logic [ROW_W-1:0]  bank_row [BANKS];

  // Read command delay line
  lpdbrw_ev_e        ev      [PIPE_DEPTH];
  logic [BANK_W-1:0] ev_bank [PIPE_DEPTH];
  logic [ROW_W-1:0]  ev_row  [PIPE_DEPTH];
  logic [COL_W-1:0]  ev_col  [PIPE_DEPTH];
  logic              ev_ap   [PIPE_DEPTH];
  logic [1:0]        ev_code [PIPE_DEPTH];
  logic [1:0]        ci;
  logic [1:0]        pi;
  lpdbrw_ev_e        e_now;
  logic              pre_rd;

  // Read burst in flight
  logic              rd_live;
  logic [BANK_W-1:0] rd_bank;
  logic [ROW_W-1:0]  rd_row;
  logic [COL_W-1:0]  rd_col;
  logic              rd_ap;
  logic [1:0]        rd_code;
  logic [PAIR_W-1:0] rd_k;
  logic [PAIR_W-1:0] rd_pairs;
  logic              rd_more;
  logic              hit_bt;
  logic              hit_pre;
  logic              rd_ap_done;
  logic [IDX_W-1:0]  new_idx0;
  logic [IDX_W-1:0]  new_idx1;
  logic [IDX_W-1:0]  cur_idx0;
  logic [IDX_W-1:0]  cur_idx1;

  // Write bookkeeping on the command clock
  logic [PAIR_W-1:0] wap_cnt;
  logic [BANK_W-1:0] wap_bank;
  logic              wr_ap_done;

  // Array written on the strobe, read on the command clock
  logic [DQ_W-1:0]   mem [MEM_N];

  lpdbrw_wr_if #(
    .ROW_W (ROW_W),
    .COL_W (COL_W),
    .DQ_W  (DQ_W)
  ) wr ();

  lpdbrw_wcap #(
    .ROW_W (ROW_W),
    .COL_W (COL_W),
    .DQ_W  (DQ_W)
  ) u_wcap (
    .wstrobe_clk (wstrobe_clk),
    .srst        (srst),
    .dq_in       (dq_in),
    .data_mask   (data_mask),
    .wr          (wr.cap)
  );

  // Pins are synchronous to the command clock; no synchroniser
  assign sel    = ~cs_n;
  assign cmd    = {ras_n, cas_n, we_n};
  assign cbank  = {bank_select_msb, bank_select_lsb};
  // Pairs start on even columns
  assign ccol   = {addr[COL_W-1:1], 1'b0};
  assign is_act = sel && (cmd == CMD_ACTIVE);
  assign is_rd  = sel && (cmd == CMD_READ);
  assign is_wr  = sel && (cmd == CMD_WRITE);
  assign is_pre = sel && (cmd == CMD_PRECHARGE);
  assign is_bt  = sel && (cmd == CMD_BTERM);
  assign rd_ok  = is_rd && bank_open[cbank];
  assign wr_ok  = is_wr && bank_open[cbank];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bank_open <= '0;
    end else begin
      if (rd_ap_done) begin
        bank_open[rd_bank] <= 1'b0;
      end
      if (wr_ap_done) begin
        bank_open[wap_bank] <= 1'b0;
      end
      if (is_pre) begin
        if (auto_precharge_bit) begin
          bank_open <= '0;
        end else begin
          bank_open[cbank] <= 1'b0;
        end
      end
      if (is_act) begin
        bank_open[cbank] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (is_act) begin
      bank_row[cbank] <= addr;
    end
  end

  // Open-bank reads, terminates and precharges enter the line; each stage is one cycle later
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ev[0] <= EV_NONE;
    end else if (rd_ok) begin
      ev[0] <= EV_READ;
    end else if (is_bt) begin
      ev[0] <= EV_BTERM;
    end else if (is_pre) begin
      ev[0] <= EV_PRE;
    end else begin
      ev[0] <= EV_NONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    ev_bank[0] <= cbank;
    ev_row[0]  <= bank_row[cbank];
    ev_col[0]  <= ccol;
    ev_ap[0]   <= auto_precharge_bit;
    ev_code[0] <= burst_len_code;
  end

  for (genvar s = 1; s < PIPE_DEPTH; s++) begin : g_pipe
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        ev[s] <= EV_NONE;
      end else begin
        ev[s] <= ev[s-1];
      end
    end
    always_ff @(posedge sys_clk) begin
      ev_bank[s] <= ev_bank[s-1];
      ev_row[s]  <= ev_row[s-1];
      ev_col[s]  <= ev_col[s-1];
      ev_ap[s]   <= ev_ap[s-1];
      ev_code[s] <= ev_code[s-1];
    end
  end

  // Latency other than 2 is served as 3
  assign ci     = (cas_latency == CL_TWO) ? 2'h1 : 2'h2;
  assign pi     = ci - 2'h1;
  assign e_now  = ev[ci];
  assign pre_rd = (ev[pi] == EV_READ);

  assign rd_pairs = lpdbrw_pairs(rd_code);
  assign rd_more  = rd_live && (rd_k < rd_pairs);
  // Terminate ignores the bank given with it
  assign hit_bt   = (e_now == EV_BTERM) && !rd_ap;
  assign hit_pre  = (e_now == EV_PRE) && !rd_ap &&
                    (ev_ap[ci] || ev_bank[ci] == rd_bank);

  assign new_idx0 = {ev_bank[ci], ev_row[ci], ev_col[ci]};
  assign new_idx1 = {ev_bank[ci], ev_row[ci], ev_col[ci] | 1'b1};
  assign cur_idx0 = {rd_bank, rd_row,
                     COL_W'(lpdbrw_col_wrap(16'(rd_col),
                                            16'({rd_k, 1'b0}), rd_code))};
  assign cur_idx1 = {cur_idx0[IDX_W-1:1], 1'b1};

  // Read output stage: one element pair per command-clock cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_live        <= 1'b0;
      rd_k           <= '0;
      rd_ap          <= 1'b0;
      rd_ap_done     <= 1'b0;
      dq_oe          <= 1'b0;
      rd_strobe_oe   <= 1'b0;
      rd_strobe_rise <= 1'b0;
    end else begin
      rd_ap_done <= 1'b0;
      if (e_now == EV_READ) begin
        // An auto-precharge read cut by another read closes rd_bank, by then the new read's bank
        if (rd_live && rd_ap) begin
          rd_ap_done <= 1'b1;
        end
        rd_live        <= 1'b1;
        rd_bank        <= ev_bank[ci];
        rd_row         <= ev_row[ci];
        rd_col         <= ev_col[ci];
        rd_ap          <= ev_ap[ci];
        rd_code        <= ev_code[ci];
        rd_k           <= 4'h1;
        dq_oe          <= 1'b1;
        rd_strobe_oe   <= 1'b1;
        rd_strobe_rise <= 1'b1;
      end else if (rd_live && (hit_bt || hit_pre)) begin
        rd_live        <= 1'b0;
        dq_oe          <= 1'b0;
        rd_strobe_oe   <= pre_rd;
        rd_strobe_rise <= 1'b0;
      end else if (rd_more) begin
        rd_k           <= rd_k + 4'h1;
        dq_oe          <= 1'b1;
        rd_strobe_oe   <= 1'b1;
        rd_strobe_rise <= 1'b1;
      end else begin
        if (rd_live && rd_ap) begin
          rd_ap_done <= 1'b1;
        end
        rd_live        <= 1'b0;
        dq_oe          <= 1'b0;
        rd_strobe_oe   <= pre_rd;
        rd_strobe_rise <= 1'b0;
      end
    end
  end

  // Falling half of the strobe is the postamble low on the last element.
  // The array read crosses from the strobe domain unsynchronised: a
  // read of a location written in the same cycle may see either value.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_dq_rise <= '0;
      rd_dq_fall <= '0;
    end else if (e_now == EV_READ) begin
      rd_dq_rise <= mem[new_idx0];
      rd_dq_fall <= mem[new_idx1];
    end else if (rd_more && !(hit_bt || hit_pre)) begin
      rd_dq_rise <= mem[cur_idx0];
      rd_dq_fall <= mem[cur_idx1];
    end
  end

  // Write command word held for the strobe side, flagged by a toggle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr.cmd_tgl <= 1'b0;
    end else if (wr_ok) begin
      wr.cmd_tgl  <= ~wr.cmd_tgl;
      wr.cmd_bank <= cbank;
      wr.cmd_row  <= bank_row[cbank];
      wr.cmd_col  <= ccol;
      wr.cmd_code <= burst_len_code;
    end
  end

  // Auto precharge after write: counted on the command clock, since
  // the strobe stops once the burst is over
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wap_cnt    <= '0;
      wr_ap_done <= 1'b0;
    end else begin
      wr_ap_done <= (wap_cnt == 4'h1);
      if (wr_ok) begin
        wap_bank <= cbank;
        wap_cnt  <= auto_precharge_bit ?
                    lpdbrw_pairs(burst_len_code) + WR_AP_TAIL : '0;
      end else if (wap_cnt != '0) begin
        wap_cnt <= wap_cnt - 4'h1;
      end
    end
  end

  // Falling strobe edge completes a pair; masked bytes keep old data
  always_ff @(negedge wstrobe_clk) begin
    if (wr.we) begin
      for (int b = 0; b < NB; b++) begin
        if (wr.rise_keep[b]) begin
          mem[wr.idx][b*8 +: 8] <= wr.rise_dq[b*8 +: 8];
        end
        if (!data_mask[b]) begin
          mem[{wr.idx[IDX_W-1:1], 1'b1}][b*8 +: 8] <= dq_in[b*8 +: 8];
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: verif/lpdbrw_checker.sv
// Assertions on the read pins of lpdbrw_core, bound to its ports.
// Assumes the bench keeps each checked burst free of other commands.
`timescale 1ns/10ps
`default_nettype none
module lpdbrw_checker
  import lpdbrw_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       cs_n,
  input wire logic       ras_n,
  input wire logic       cas_n,
  input wire logic       we_n,
  input wire logic       bank_select_msb,
  input wire logic       bank_select_lsb,
  input wire logic       auto_precharge_bit,
  input wire logic [1:0] cas_latency,
  input wire logic [1:0] burst_len_code,
  input wire logic       dq_oe,
  input wire logic       rd_strobe_rise,
  input wire logic       rd_strobe_oe
);
  logic [2:0]       code;
  logic [1:0]       bk;
  logic [1:0]       last_bk;
  logic [BANKS-1:0] open;
  logic             cl2, rd, bt, pre, wr, quiet, vr;
  assign code  = {ras_n, cas_n, we_n};
  assign bk    = {bank_select_msb, bank_select_lsb};
  assign cl2   = cas_latency == CL_TWO;
  assign rd    = !cs_n && code == CMD_READ;
  assign bt    = !cs_n && code == CMD_BTERM;
  assign pre   = !cs_n && code == CMD_PRECHARGE;
  assign wr    = !cs_n && code == CMD_WRITE;
  assign quiet = !(rd || bt || pre);
  assign vr    = rd && open[bk];
  // Bank state kept only to tell live reads from ignored ones
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      open <= '0;
    end else if (!cs_n && code == CMD_ACTIVE) begin
      open[bk] <= 1'b1;
    end else if (pre && auto_precharge_bit) begin
      open <= '0;
    end else if (pre || (vr && auto_precharge_bit)) begin
      open[bk] <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (vr) begin
      last_bk <= bk;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_pre;
    $rose(rd_strobe_oe) |-> !dq_oe && !rd_strobe_rise ##1 $rose(dq_oe);
  endproperty
  a_pre: assert property (p_pre)
    else $error("read preamble wrong");
  property p_on;
    dq_oe |-> rd_strobe_oe && rd_strobe_rise;
  endproperty
  a_on: assert property (p_on)
    else $error("data driven without strobe");
  property p_align;
    $rose(dq_oe) |-> (cl2 ? $past(vr, 3) : $past(vr, 4));
  endproperty
  a_align: assert property (p_align)
    else $error("first read pair off latency");
  property p_end;
    vr && cl2 && burst_len_code == 2'h1 ##1 quiet [*3] |=>
      dq_oe ##1 !dq_oe;
  endproperty
  a_end: assert property (p_end)
    else $error("burst of four wrong length");
  property p_rel;
    $fell(dq_oe) |-> !rd_strobe_rise ##1 (dq_oe || !rd_strobe_oe);
  endproperty
  a_rel: assert property (p_rel)
    else $error("strobe not released after burst");
  property p_rr;
    vr && cl2 && burst_len_code != 2'h0 ##1
      (vr && burst_len_code == 2'h1) ##1 quiet |=>
      dq_oe [*3] ##1 !dq_oe;
  endproperty
  a_rr: assert property (p_rr)
    else $error("read over read not seamless");
  property p_bt;
    vr && cl2 && !auto_precharge_bit && burst_len_code != 2'h0 ##1
      bt ##1 quiet |=> dq_oe ##1 !dq_oe;
  endproperty
  a_bt: assert property (p_bt)
    else $error("terminate did not cut read");
  property p_pc;
    vr && cl2 && !auto_precharge_bit && burst_len_code != 2'h0 ##1
      (pre && (auto_precharge_bit || bk == last_bk)) ##1 quiet |=>
      dq_oe ##1 !dq_oe;
  endproperty
  a_pc: assert property (p_pc)
    else $error("precharge did not cut read");
  property p_wr;
    wr && !rd_strobe_oe && !dq_oe ##1 quiet [*3] |=>
      !dq_oe && !rd_strobe_oe;
  endproperty
  a_wr: assert property (p_wr)
    else $error("pins driven during write");
endmodule
bind lpdbrw_core lpdbrw_checker chk (
  .sys_clk, .srst, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_msb,
  .bank_select_lsb, .auto_precharge_bit, .cas_latency, .burst_len_code,
  .dq_oe, .rd_strobe_rise, .rd_strobe_oe
);
`default_nettype wire

// File: verif/lpdbrw_ctl_model.sv
// Controller side of the write link: strobe clock and write data.
// Assumes one four-element burst per go pulse, pulses well apart.
`timescale 1ns/10ps
`default_nettype none
module lpdbrw_ctl_model
  import lpdbrw_pkg::*;
#(
  parameter int DQ_W = 16
) (
  input  wire logic              go,
  input  wire logic [DQ_W-1:0]   word,
  input  wire logic [DQ_W/8-1:0] mask,
  output logic                   wstrobe_clk,
  output logic [DQ_W-1:0]        dq_in,
  output logic [DQ_W/8-1:0]      data_mask
);
  // Free running: the core needs edges through reset and preamble
  initial begin
    wstrobe_clk = 1'b0;
    dq_in = '0;
    data_mask = '1;
    #7;
    // A rising edge falls in any 30 ns span, so one lands in the window
    forever #15 wstrobe_clk = ~wstrobe_clk;
  end
  // One word for all elements, so capture phase cannot skew it
  always @(posedge go) begin
    dq_in = word;
    data_mask = mask;
    // Core takes ~4 strobe edges to see the token, then two pairs
    repeat (12) @(negedge wstrobe_clk);
    #3;
    // Released bus shows the inverse, never a stale copy
    dq_in = ~word;
    data_mask = ~mask;
  end
endmodule
`default_nettype wire

// File: verif/lpddr_burst_read_write_test.sv
// Self-checking bench for lpdbrw_core with a controller-side model.
// Assumes the checker is bound; read pairs are queued and compared.
`timescale 1ns/10ps
`default_nettype none
module lpddr_burst_read_write_test
  import lpdbrw_pkg::*;
;
  logic             sys_clk, srst, cs_n, ras_n, cas_n, we_n, go;
  logic             bank_select_msb, bank_select_lsb, auto_precharge_bit;
  logic             wstrobe_clk, dq_oe, rd_strobe_rise, rd_strobe_oe;
  logic [3:0]       addr;
  logic [1:0]       cas_latency, burst_len_code, mask, data_mask;
  logic [15:0]      word, dq_in, rd_dq_rise, rd_dq_fall;
  logic [15:0]      mem [BANKS][16][16];
  logic [3:0]       row [BANKS];
  logic [BANKS-1:0] open;
  logic [31:0]      q [$];
  int               n_errors, checks;
  integer           seed;
  lpdbrw_core lpdbrw_core_inst (
    .sys_clk, .srst, .wstrobe_clk, .cs_n, .ras_n, .cas_n, .we_n,
    .bank_select_msb, .bank_select_lsb, .addr, .auto_precharge_bit,
    .cas_latency, .burst_len_code, .dq_in, .data_mask, .rd_dq_rise,
    .rd_dq_fall, .dq_oe, .rd_strobe_rise, .rd_strobe_oe
  );
  lpdbrw_ctl_model lpdbrw_ctl_model_inst (
    .go, .word, .mask, .wstrobe_clk, .dq_in, .data_mask
  );
  always #50 sys_clk = ~sys_clk;
  task automatic cmp_pair(input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e || $isunknown(s)) begin
      n_errors++;
      $display("ERROR read pair expected %h seen %h", e, s);
    end
  endtask
  task automatic cmp_bit(input string nm, input logic e, input logic s);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", nm, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Offset 4 ns keeps clear of every strobe edge
  task automatic cmd(input logic [2:0] c, input int b, input logic [3:0] a,
                     input logic ap, input logic [1:0] bl);
    @(posedge sys_clk);
    #4;
    {cs_n, ras_n, cas_n, we_n} = {1'b0, c};
    {bank_select_msb, bank_select_lsb} = 2'(b);
    addr = a;
    auto_precharge_bit = ap;
    burst_len_code = bl;
  endtask
  task automatic nop(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #4;
      cs_n = 1'b1;
    end
  endtask
  task automatic act(input int b, input logic [3:0] r);
    cmd(CMD_ACTIVE, b, r, 1'b0, 2'h1);
    row[b] = r;
    open[b] = 1'b1;
  endtask
  task automatic wr(input int b, input logic [3:0] c, input logic [1:0] m);
    logic [3:0] ce;
    word = 16'($random(seed));
    mask = m;
    cmd(CMD_WRITE, b, c, 1'b0, 2'h1);
    go = 1'b1;
    for (int e = 0; e < 4; e++) begin
      ce = (c & 4'hc) | ((c + 4'(e)) & 4'h3);
      for (int k = 0; k < 2; k++) begin
        if (!m[k]) mem[b][row[b]][ce][k*8 +: 8] = word[k*8 +: 8];
      end
    end
    nop(8);
    go = 1'b0;
  endtask
  task automatic rd(input int b, input logic [3:0] c, input logic [1:0] bl,
                    input logic ap, input int n);
    logic [3:0] m, c0;
    cmd(CMD_READ, b, c, ap, bl);
    if (open[b]) begin
      m = 4'((2 << bl) - 1);
      for (int j = 0; j < n; j++) begin
        c0 = ((c & 4'he) & ~m) | (((c & 4'he) + 4'(2 * j)) & m);
        q.push_back({mem[b][row[b]][c0], mem[b][row[b]][c0 | 4'h1]});
      end
      if (ap) open[b] = 1'b0;
    end
  endtask
  always @(posedge sys_clk) begin
    #4;
    if (dq_oe === 1'b1) begin
      cmp_pair(q.size() > 0 ? q.pop_front() : 'x, {rd_dq_rise, rd_dq_fall});
    end
  end
  // About thirty times the expected run
  initial begin
    #400000;
    n_errors++;
    finish_test();
  end
  initial begin
    seed = 32'hde1a2902;
    sys_clk = 1'b0;
    srst = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    {bank_select_msb, bank_select_lsb, auto_precharge_bit, go} = 4'h0;
    addr = 4'h0;
    cas_latency = CL_TWO;
    burst_len_code = BL_CODE_RST;
    word = 16'h0;
    mask = 2'h0;
    open = '0;
    n_errors = 0;
    checks = 0;
    repeat (6) @(posedge sys_clk);
    #4;
    srst = 1'b0;
    cmp_bit("dq_oe", 1'b0, dq_oe);
    cmp_bit("rd_strobe_oe", 1'b0, rd_strobe_oe);
    act(0, 4'h1);
    act(1, 4'h2);
    nop(2);
    wr(0, 4'h0, 2'h0);
    wr(0, 4'h0, 2'h1);
    wr(0, 4'h4, 2'h0);
    wr(1, 4'h0, 2'h0);
    wr(1, 4'h0, 2'h2);
    for (int i = 0; i < 2; i++) begin
      cas_latency = i ? CL_THREE : CL_TWO;
      rd(0, 4'h2, 2'h1, 1'b0, 2);
      nop(6);
    end
    cas_latency = CL_TWO;
    for (int i = 0; i < 4; i++) begin
      rd(0, 4'($random(seed)) & 4'h6, 2'h1, 1'b0, i == 3 ? 2 : 1);
    end
    nop(6);
    rd(0, 4'h0, 2'h2, 1'b0, 1);
    cmd(CMD_BTERM, 3, 4'h0, 1'b0, 2'h1);
    nop(6);
    rd(1, 4'h0, 2'h1, 1'b1, 2);
    cmd(CMD_BTERM, 1, 4'h0, 1'b0, 2'h1);
    nop(8);
    rd(1, 4'h0, 2'h1, 1'b0, 2);
    nop(6);
    rd(0, 4'h4, 2'h1, 1'b0, 2);
    nop(1);
    cmd(CMD_PRECHARGE, 0, 4'h0, 1'b0, 2'h1);
    open[0] = 1'b0;
    nop(6);
    rd(0, 4'h4, 2'h1, 1'b0, 2);
    nop(6);
    act(0, 4'h1);
    nop(2);
    rd(0, 4'h0, 2'h1, 1'b0, 1);
    cmd(CMD_PRECHARGE, 0, 4'h0, 1'b0, 2'h1);
    open[0] = 1'b0;
    nop(8);
    cmp_bit("queue empty", 1'b1, q.size() == 0);
    cmp_bit("dq_oe", 1'b0, dq_oe);
    finish_test();
  end
endmodule
`default_nettype wire
